// ==== hw/bcdsk_cfg.svh ====
`ifndef BCDSK_CFG_SVH
`define BCDSK_CFG_SVH
`define BCDSK_NIB_LIMIT     4'h9
`define BCDSK_NIB_ADJ       4'h6
`define BCDSK_PHASES        2'h3
`define BCDSK_PROC_PHASE    2'h2
`define BCDSK_W_RESET       8'h00
`endif

// ==== hw/bcdsk_pkg.sv ====
package bcdsk_pkg;
	typedef enum logic [1:0] {
		BCDSK_OP_NONE,
		BCDSK_OP_CMP_LT,
		BCDSK_OP_DEC_ADJ
	} bcdsk_op_type;

	typedef enum {
		BCDSK_ST_RUN,
		BCDSK_ST_IDLE1,
		BCDSK_ST_IDLE2
	} bcdsk_state_type;
endpackage : bcdsk_pkg

// ==== hw/bcdsk_dec_adj.sv ====
`timescale 1ns/1ps
`include "bcdsk_cfg.svh"
module bcdsk_dec_adj (
	input  wire logic [7:0] i_w,
	input  wire logic       i_carry,
	input  wire logic       i_digit_carry,
	output logic      [7:0] o_w,
	output logic            o_carry
);
	logic [4:0] lo;
	logic [4:0] hi;
	always_comb begin
		lo = {1'b0, i_w[3:0]};
		if (i_w[3:0] > `BCDSK_NIB_LIMIT || i_digit_carry) begin
			lo = lo + {1'b0, `BCDSK_NIB_ADJ};
		end
		// Low-nibble carry ripples into the high nibble before its test
		hi = {1'b0, i_w[7:4]} + {4'h0, lo[4]};
		if (hi > {1'b0, `BCDSK_NIB_LIMIT} || i_carry) begin
			hi = hi + {1'b0, `BCDSK_NIB_ADJ};
		end
		o_w     = {hi[3:0], lo[3:0]};
		o_carry = hi[4] | i_carry;
	end
endmodule : bcdsk_dec_adj

// ==== hw/bcdsk_core.sv ====
`timescale 1ns/1ps
`include "bcdsk_cfg.svh"
// Summary of operation
// - A less-than compare-and-skip takes one instruction cycle if false, two if it skips.
// - A skip over a two-word instruction makes the compare take three cycles in all.
// - Each skip cycle is idle in all four phases, and the compare writes nothing in its last phase.
// - Decimal adjust turns the working register after a packed BCD add into valid packed BCD.
module bcdsk_core (
	input  wire logic                   I_CLK,
	input  wire logic                   I_SYS_RST,
	input  wire logic                   I_CE,
	input  wire logic                   I_START,
	input  wire bcdsk_pkg::bcdsk_op_type I_OP,
	input  wire logic [7:0]             I_FILE_DATA,
	input  wire logic                   I_NEXT_TWO_WORD,
	input  wire logic                   I_W_LOAD,
	input  wire logic [7:0]             I_W_LOAD_DATA,
	input  wire logic                   I_FLAG_LOAD,
	input  wire logic                   I_CARRY_IN,
	input  wire logic                   I_DIGIT_CARRY_IN,
	output logic      [1:0]             O_PHASE,
	output logic                        O_BUSY,
	output logic                        O_DISCARD,
	output logic                        O_CYCLE_END,
	output logic                        O_W_WRITE,
	output logic      [7:0]             O_W,
	output logic                        O_CARRY,
	output logic                        O_DIGIT_CARRY
);
	import bcdsk_pkg::*;

	// Phase decoding is shared by the sequencer and the outputs
	function automatic logic is_last_phase(input logic [1:0] phase);
		is_last_phase = phase == `BCDSK_PHASES;
	endfunction : is_last_phase

	// Operands are read and the result is formed in the third phase
	function automatic logic is_process_phase(input logic [1:0] phase);
		is_process_phase = phase == `BCDSK_PROC_PHASE;
	endfunction : is_process_phase

	function automatic logic is_compare(input bcdsk_op_type op);
		is_compare = op == BCDSK_OP_CMP_LT;
	endfunction : is_compare

	function automatic logic is_adjust(input bcdsk_op_type op);
		is_adjust = op == BCDSK_OP_DEC_ADJ;
	endfunction : is_adjust

	// A start is only taken by an idle sequencer, so a strobe that arrives
	// mid-instruction cannot restart the phases or swap the operand
	function automatic logic start_taken(
		input logic         start,
		input bcdsk_op_type op,
		input logic         seq_busy
	);
		start_taken = start && op != BCDSK_OP_NONE && !seq_busy;
	endfunction : start_taken

	// Only a compare whose condition held may ask for skip cycles
	function automatic logic skip_wanted(input bcdsk_op_type op, input logic skip);
		skip_wanted = is_compare(op) && skip;
	endfunction : skip_wanted

	// After the first idle cycle a second follows only for a two-word victim
	function automatic bcdsk_state_type after_first_idle(input logic two_word);
		after_first_idle = two_word ? BCDSK_ST_IDLE2 : BCDSK_ST_RUN;
	endfunction : after_first_idle

	typedef struct packed {
		bcdsk_state_type state;
		logic [1:0]      phase;
		logic            active;
		bcdsk_op_type    op;
		logic [7:0]      file;
		logic            two_word;
		logic            skip;
		logic            w_write;
		logic [7:0]      w;
		logic            carry;
		logic            digit_carry;
	} bcdsk_regs_type;

	bcdsk_regs_type r;
	bcdsk_regs_type next_r;
	logic [7:0]     adj_w;
	logic           adj_carry;
	logic           busy;
	logic           last_phase;
	logic           process_phase;
	logic           take_start;

	bcdsk_dec_adj u_adj (
		.i_w           (r.w),
		.i_carry       (r.carry),
		.i_digit_carry (r.digit_carry),
		.o_w           (adj_w),
		.o_carry       (adj_carry)
	);

	// Busy covers the instruction's own cycle and every idle cycle after it
	assign busy          = r.active || r.state != BCDSK_ST_RUN;
	assign last_phase    = is_last_phase(r.phase);
	assign process_phase = is_process_phase(r.phase);
	assign take_start    = start_taken(I_START, I_OP, busy);

	// One instruction cycle is four enabled clocks, phases 0 to 3.
	// Phases 0 and 1 do no work, phase 2 reads the operands and processes them,
	// and phase 3 writes back (adjust) or does nothing (compare).
	// A compare that holds leaves the skip request set at phase 3; the
	// sequencer then runs one idle cycle, or two when the discarded
	// instruction occupies two words, before the fetch side may start again.
	// Idle cycles change only the phase counter and the sequencer state, so the fetched
	// instruction is discarded without side effects.
	// Loads of W and the flags from outside are honoured in any cycle; an
	// adjust writeback in the same cycle wins, as its result is newer.
	// Clock enable freezes the whole register set, phase included, so a
	// stalled core resumes mid-instruction where it stopped.

	always_comb begin
		next_r         = r;
		next_r.w_write = 1'b0;
		if (I_W_LOAD) begin
			next_r.w = I_W_LOAD_DATA;
		end
		if (I_FLAG_LOAD) begin
			next_r.carry       = I_CARRY_IN;
			next_r.digit_carry = I_DIGIT_CARRY_IN;
		end

		// Phases advance only while the instruction or its skip cycles run
		if (busy) begin
			next_r.phase = r.phase + 2'h1;
		end
		case (r.state)
			BCDSK_ST_RUN: begin
				if (!r.active) begin
					if (take_start) begin
						next_r.active   = 1'b1;
						next_r.op       = I_OP;
						next_r.file     = I_FILE_DATA;
						next_r.two_word = I_NEXT_TWO_WORD;
						next_r.phase    = 2'h0;
					end
				end else begin
					if (process_phase && is_compare(r.op)) begin
						// Unsigned subtract; borrow means file below W
						next_r.skip = r.file < r.w;
					end

					// Writeback lands as phase 3 opens and stands for one clock
					if (process_phase && is_adjust(r.op)) begin
						next_r.w       = adj_w;
						next_r.carry   = adj_carry;
						next_r.w_write = 1'b1;
					end

					if (last_phase) begin
						// Compare writes nothing in its last phase
						next_r.active = 1'b0;
						if (skip_wanted(r.op, r.skip)) begin
							next_r.state = BCDSK_ST_IDLE1;
						end
						next_r.skip = 1'b0;
					end
				end
			end
			// Idle cycles only step the sequencer state at phase 3; nothing else is touched here
			BCDSK_ST_IDLE1: begin
				if (last_phase) begin
					next_r.state = after_first_idle(r.two_word);
				end
			end
			BCDSK_ST_IDLE2: begin
				if (last_phase) begin
					next_r.state = BCDSK_ST_RUN;
				end
			end
			default: begin
				next_r.state = BCDSK_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			r <= '{
				state:       BCDSK_ST_RUN,
				phase:       2'h0,
				active:      1'b0,
				op:          BCDSK_OP_NONE,
				file:        8'h00,
				two_word:    1'b0,
				skip:        1'b0,
				w_write:     1'b0,
				w:           `BCDSK_W_RESET,
				carry:       1'b0,
				digit_carry: 1'b0
			};
		end else if (I_CE) begin
			r <= next_r;
		end
	end

	// Idle cycles drive the discard marker, busy, the phase and the cycle-end marker, but never a W write
	assign O_PHASE       = r.phase;
	assign O_BUSY        = busy;
	assign O_DISCARD     = r.state != BCDSK_ST_RUN;
	// The fetch side counts instruction cycles on this marker
	assign O_CYCLE_END   = busy && last_phase;
	assign O_W_WRITE     = r.w_write;
	assign O_W           = r.w;
	assign O_CARRY       = r.carry;
	assign O_DIGIT_CARRY = r.digit_carry;
endmodule : bcdsk_core

// ==== sim/bcdsk_checker.sv ====
`timescale 1ns/1ps
module bcdsk_checker (
	input logic       I_CLK,
	input logic       I_SYS_RST,
	input logic [1:0] O_PHASE,
	input logic       O_DISCARD,
	input logic       O_W_WRITE,
	input logic [7:0] O_W,
	input logic       O_CARRY
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_skip_full: assert property ($rose(O_DISCARD) |-> O_DISCARD[*4])
		else $error("short skip");
	a_skip_max: assert property (O_DISCARD[*8] |=> !O_DISCARD)
		else $error("long skip");
	a_idle_nowr: assert property (O_DISCARD |-> !O_W_WRITE)
		else $error("write in skip");
	a_bcd_out: assert property (O_W_WRITE |-> O_W[7:4] <= 4'h9 && O_W[3:0] <= 4'h9)
		else $error("not bcd");
	a_wr_once: assert property (O_W_WRITE |-> O_PHASE == 2'h3 ##1 !O_W_WRITE)
		else $error("bad write");
	c_skip: cover property ($rose(O_DISCARD));
	c_two: cover property (O_DISCARD[*8]);
	c_adj: cover property (O_W_WRITE && O_CARRY);
endmodule : bcdsk_checker
bind bcdsk_core bcdsk_checker u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .O_PHASE(O_PHASE),
	.O_DISCARD(O_DISCARD), .O_W_WRITE(O_W_WRITE), .O_W(O_W), .O_CARRY(O_CARRY));

// ==== sim/bcdsk_fetch_model.sv ====
`timescale 1ns/1ps
// Fetch side: counts instruction cycles spent since the last start
module bcdsk_fetch_model (
	input  logic clk,
	input  logic start,
	input  logic cyc_end,
	output int   cycles
);
	always @(posedge clk) begin
		if (start)
			cycles <= 0;
		else if (cyc_end)
			cycles <= cycles + 1;
	end
endmodule : bcdsk_fetch_model

// ==== sim/bcd_adjust_and_skip_timing_tb.sv ====
`timescale 1ns/1ps
module bcd_adjust_and_skip_timing_tb;
	import bcdsk_pkg::*;
	logic         I_CLK = 0, I_SYS_RST = 1, I_START = 0, I_TW = 0, I_WL = 0, I_FL = 0, I_C = 0, I_DC = 0;
	logic [7:0]   I_F = 8'h00, I_WD = 8'h00, O_W;
	bcdsk_op_type I_OP = BCDSK_OP_NONE;
	logic [1:0]   O_PHASE;
	logic         O_BUSY, O_DISCARD, O_CYCLE_END, O_W_WRITE, O_CARRY, O_DC;
	int           cycles, n_errors = 0, comparisons = 0;
	initial forever #5 I_CLK = ~I_CLK;
	bcdsk_core uut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(1'b1), .I_START(I_START),
		.I_OP(I_OP), .I_FILE_DATA(I_F), .I_NEXT_TWO_WORD(I_TW), .I_W_LOAD(I_WL),
		.I_W_LOAD_DATA(I_WD), .I_FLAG_LOAD(I_FL), .I_CARRY_IN(I_C), .I_DIGIT_CARRY_IN(I_DC),
		.O_PHASE(O_PHASE), .O_BUSY(O_BUSY), .O_DISCARD(O_DISCARD), .O_CYCLE_END(O_CYCLE_END),
		.O_W_WRITE(O_W_WRITE), .O_W(O_W), .O_CARRY(O_CARRY), .O_DIGIT_CARRY(O_DC));
	bcdsk_fetch_model fm (.clk(I_CLK), .start(I_START), .cyc_end(O_CYCLE_END), .cycles(cycles));
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input bit ok);
		comparisons++;
		if (!ok) begin
			n_errors++;
			$display("[ERR] %0t mismatch", $time);
		end
	endtask : chk
	task automatic load(input logic [7:0] w, input logic c, input logic dc);
		@(posedge I_CLK);
		I_WL <= 1'b1;
		I_FL <= 1'b1;
		I_WD <= w;
		I_C <= c;
		I_DC <= dc;
		@(posedge I_CLK);
		I_WL <= 1'b0;
		I_FL <= 1'b0;
	endtask : load
	// Waits out the whole instruction, skip cycles included
	task automatic issue(input bcdsk_op_type op, input logic [7:0] f, input logic tw);
		int k;
		@(posedge I_CLK);
		I_OP <= op;
		I_F <= f;
		I_TW <= tw;
		I_START <= 1'b1;
		@(posedge I_CLK);
		I_START <= 1'b0;
		// Busy is looked at mid-cycle, once the launching edge has settled
		for (k = 0; k < 40; k++) begin
			@(negedge I_CLK);
			if (O_BUSY === 1'b0)
				break;
		end
		chk(k < 40);
		if (k == 40)
			tally_and_finish();
	endtask : issue
	task automatic t_cmp();
		load(8'h50, 1'b0, 1'b0);
		issue(BCDSK_OP_CMP_LT, 8'h4f, 1'b0);
		chk(cycles == 2);
		issue(BCDSK_OP_CMP_LT, 8'h50, 1'b1);
		chk(cycles == 1);
		issue(BCDSK_OP_CMP_LT, 8'h00, 1'b1);
		chk(cycles == 3);
		chk(O_W === 8'h50);
		$display("compare done");
	endtask : t_cmp
	task automatic t_adj();
		load(8'ha5, 1'b0, 1'b0);
		issue(BCDSK_OP_DEC_ADJ, 8'h00, 1'b0);
		chk(O_W === 8'h05 && O_CARRY === 1'b1 && cycles == 1);
		load(8'h41, 1'b0, 1'b1);
		issue(BCDSK_OP_DEC_ADJ, 8'h00, 1'b0);
		chk(O_W === 8'h47 && O_CARRY === 1'b0 && O_DC === 1'b1);
		load(8'h9a, 1'b0, 1'b0);
		issue(BCDSK_OP_DEC_ADJ, 8'h00, 1'b0);
		chk(O_W === 8'h00 && O_CARRY === 1'b1);
		$display("adjust done");
	endtask : t_adj
	initial begin
		repeat (8) @(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		t_cmp();
		t_adj();
		tally_and_finish();
	end
endmodule : bcd_adjust_and_skip_timing_tb
